// file: rtl/scd_pkg.sv
`default_nettype none
package scd_pkg;
    // oscillator variant of the device
    typedef enum logic [2:0] {
        SCD_VAR_RC      = 3'h0,
        SCD_VAR_R       = 3'h1,
        SCD_VAR_XTALCER = 3'h2,
        SCD_VAR_XTAL    = 3'h3,
        SCD_VAR_CERAMIC = 3'h4
    } scd_variant_t;

    // standby state, gray along run -> halt -> stop -> wait
    typedef enum logic [1:0] {
        SCD_ST_RUN  = 2'h0,
        SCD_ST_HALT = 2'h1,
        SCD_ST_STOP = 2'h3,
        SCD_ST_WAIT = 2'h2
    } scd_state_t;

    localparam int SCD_DIV_W          = 8;
    localparam int SCD_CPU_RC_DIV     = 2;
    localparam int SCD_XC_BASE_DIV    = 6;
    localparam int SCD_XC_CPU_DIV     = 12;
    localparam int SCD_XC_TMR_DIV     = 8;
    localparam int SCD_XT_PPG_DIV     = 2;
    localparam int SCD_XT_FAST_DIV    = 8;
    localparam int SCD_XT_FAST16_DIV  = 16;
    localparam int SCD_XT_SLOW_DIV    = 32;
    localparam int SCD_XT_TMR_DIV     = 128;
    localparam int SCD_CLK_HZ         = 50_000_000;
    localparam int SCD_WAIT_US        = 10;
    localparam int SCD_WAIT_CYC       = SCD_WAIT_US * (SCD_CLK_HZ / 1_000_000);
    localparam logic [SCD_DIV_W-1:0] SCD_DIV_RST = 8'h00;

    // per-output clock enables, one pulse per divided period
    typedef struct packed {
        logic base;
        logic cpu;
        logic cpu_out;
        logic timer;
        logic pulse_gen;
        logic display;
    } scd_clk_en_t;

    typedef struct packed {
        scd_state_t               st;
        logic                     halt_ff;
        logic                     stop_ff;
        logic [1:0]               rst_sync;
        logic [1:0]               ext_sync;
        logic                     rst_prev;
        logic [SCD_DIV_W-1:0]     osc_cnt;
        logic [SCD_DIV_W-1:0]     sys_cnt;
        logic [15:0]              wait_cnt;
        logic                     int_reset;
        scd_clk_en_t              en;
    } scd_regs_t;
endpackage : scd_pkg
`default_nettype wire

// file: rtl/scd_standby_clock.sv
// Summary of operation
// RL1 - rc variant: cpu clock is base clock divided by two
// RL2 - rc variant stop halts oscillator and divider; no base or cpu clock
// RL3 - halt stops only the divide-by-two; base clock continues
// RL4 - external clock: stop and halt gate only the cpu clock
// RL5 - crystal/ceramic: base /6, cpu and copy /12, timer /8
// RL6 - base clock feeds timer and syncs second interrupt gating
// RL7 - stop sets stop ff; reset high clears; clocks resume when reset low; code restarts base clock once stop ff clears, reset still high
// RL8 - halt sets halt ff; cleared by release or reset falling edge
// RL9 - crystal: pulse gen /2, fast /8 or /16, slow and display /32, timer /128
// RL10 - speed select 1 picks fast clock, 0 picks slow /32 clock
// RL11 - display always /32, pulse generator always /2
// RL12 - crystal: selected system clock /2 is cpu clock and feeds timer control
// RL13 - crystal: stop halts oscillation, clears dividers; reset restarts
// RL14 - crystal: halt ff set by stop and reset; cleared by release or delayed reset
// RL15 - ceramic: base is oscillator, cpu half of it, blocked while halted
// RL16 - ceramic: halt ff held set while reset input high
// RL17 - resistor types leave stop by interrupt or reset; others reset only
// RL18 - gating and restart glitch-free, no shortened phases downstream
`default_nettype none
module scd_standby_clock #(
    parameter int WAIT_CYC = scd_pkg::SCD_WAIT_CYC
) (
    // clock and reset
    input  wire logic                 CLK_SYS_I,
    input  wire logic                 ARST_N_I,
    // configuration
    input  wire scd_pkg::scd_variant_t VARIANT_I,
    input  wire logic                 EXT_CLOCK_I,
    input  wire logic                 FAST16_PART_I,
    input  wire logic                 CLOCK_SPEED_SELECT_BIT_I,
    // oscillator input tick, one pulse per oscillator period
    input  wire logic                 OSC_TICK_I,
    // cpu side
    input  wire logic                 STOP_INSTR_I,
    input  wire logic                 HALT_INSTR_I,
    input  wire logic                 RELEASE_I,
    input  wire logic                 RESET_PIN_I,
    // derived clock enables
    output scd_pkg::scd_clk_en_t      CLK_EN_O,
    output logic                      TIMER_COUNT_PULSE_EN_O,
    output logic                      INT_SYNC_EN_O,
    // status
    output logic                      DELAYED_INTERNAL_RESET_O,
    output logic                      HALT_O,
    output logic                      STOP_O
);
    // the wait counter is 16 bits wide and must count at least once
    if (WAIT_CYC < 1 || WAIT_CYC > 65535) begin : g_bad_wait
        $error("WAIT_CYC out of range");
    end

    scd_pkg::scd_regs_t r_reg;
    scd_pkg::scd_regs_t r_next;

    logic rst_hi;
    logic rst_fall;
    logic osc_run;
    logic is_resistor;
    logic is_xtal;
    logic is_xc;
    logic is_cer;
    logic [scd_pkg::SCD_DIV_W-1:0] fast_div;
    logic sys_tick;

    always_comb begin
        rst_hi      = r_reg.rst_sync[1];
        rst_fall    = r_reg.rst_prev & ~rst_hi;
        is_resistor = (VARIANT_I == scd_pkg::SCD_VAR_RC)
                    | (VARIANT_I == scd_pkg::SCD_VAR_R);
        is_xtal     = (VARIANT_I == scd_pkg::SCD_VAR_XTAL);
        is_xc       = (VARIANT_I == scd_pkg::SCD_VAR_XTALCER);
        is_cer      = (VARIANT_I == scd_pkg::SCD_VAR_CERAMIC);
        // RL4 external clock bypass
        osc_run     = OSC_TICK_I & (~r_reg.stop_ff | r_reg.ext_sync[1]);
        fast_div    = FAST16_PART_I
                    ? 8'(scd_pkg::SCD_XT_FAST16_DIV)
                    : 8'(scd_pkg::SCD_XT_FAST_DIV);
        sys_tick    = 1'b0;
        r_next      = r_reg;
        r_next.rst_sync = {r_reg.rst_sync[0], RESET_PIN_I};
        r_next.ext_sync = {r_reg.ext_sync[0], EXT_CLOCK_I};
        r_next.rst_prev = rst_hi;
        r_next.en       = '0;

        // RL2 RL13 dividers cleared while stopped without external clock
        if (r_reg.stop_ff && !r_reg.ext_sync[1]) begin
            r_next.osc_cnt = scd_pkg::SCD_DIV_RST;
            r_next.sys_cnt = scd_pkg::SCD_DIV_RST;
        end else if (osc_run) begin
            r_next.osc_cnt = r_reg.osc_cnt + 8'h01;
            if (is_xc) begin
                // RL5 divide by 6/12/8 from one 24-step count
                if (r_reg.osc_cnt >= 8'(scd_pkg::SCD_XC_CPU_DIV * 2 - 1)) begin
                    r_next.osc_cnt = scd_pkg::SCD_DIV_RST;
                end
                r_next.en.base  = (r_reg.osc_cnt %
                    8'(scd_pkg::SCD_XC_BASE_DIV)) == 8'h00;
                r_next.en.timer = (r_reg.osc_cnt %
                    8'(scd_pkg::SCD_XC_TMR_DIV)) == 8'h00;
                r_next.en.cpu_out = (r_reg.osc_cnt %
                    8'(scd_pkg::SCD_XC_CPU_DIV)) == 8'h00;
            end else if (is_xtal) begin
                // RL9 binary chain up to /128
                if (r_reg.osc_cnt >= 8'(scd_pkg::SCD_XT_TMR_DIV - 1)) begin
                    r_next.osc_cnt = scd_pkg::SCD_DIV_RST;
                end
                // RL11 fixed-rate outputs independent of speed bit
                r_next.en.pulse_gen = (r_reg.osc_cnt %
                    8'(scd_pkg::SCD_XT_PPG_DIV)) == 8'h00;
                r_next.en.display = (r_reg.osc_cnt %
                    8'(scd_pkg::SCD_XT_SLOW_DIV)) == 8'h00;
                r_next.en.timer = r_reg.osc_cnt == 8'h00;
                // RL10 speed select mux
                sys_tick = CLOCK_SPEED_SELECT_BIT_I
                    ? (r_reg.osc_cnt % fast_div) == 8'h00
                    : (r_reg.osc_cnt %
                       8'(scd_pkg::SCD_XT_SLOW_DIV)) == 8'h00;
                r_next.en.base = sys_tick;
            end else begin
                // RL15 base is oscillator directly
                r_next.osc_cnt = scd_pkg::SCD_DIV_RST;
                r_next.en.base = 1'b1;
            end
        end

        // RL1 divide-by-two of base; RL12 same for crystal system clock
        if (r_next.en.base && !is_xc) begin
            r_next.sys_cnt = r_reg.sys_cnt ^ 8'h01;
            // RL3 halt inhibits only this stage; RL18 whole periods kept
            r_next.en.cpu = r_reg.sys_cnt[0] & ~r_reg.halt_ff
                          & ~r_reg.stop_ff;
        end
        if (is_xc) begin
            r_next.en.cpu = r_next.en.cpu_out & ~r_reg.halt_ff
                          & ~r_reg.stop_ff;
        end
        r_next.en.cpu_out = r_next.en.cpu;

        // RL14 delayed internal reset after reset pin falls
        if (rst_hi) begin
            r_next.int_reset = 1'b1;
            r_next.wait_cnt  = 16'(WAIT_CYC);
        end else if (r_reg.int_reset) begin
            if (r_reg.wait_cnt <= 16'h0001) begin
                r_next.int_reset = 1'b0;
            end else begin
                r_next.wait_cnt = r_reg.wait_cnt - 16'h0001;
            end
        end

        // RL7 stop ff set by instruction, cleared by reset high
        if (rst_hi) begin
            r_next.stop_ff = 1'b0;
        // RL17 resistor types also leave stop on interrupt
        end else if (r_reg.stop_ff && RELEASE_I && is_resistor) begin
            r_next.stop_ff = 1'b0;
        end else if (STOP_INSTR_I && !is_cer) begin
            r_next.stop_ff = 1'b1;
        end

        // RL8 halt ff set by instruction, cleared by release or reset fall
        if ((rst_hi && (is_xtal || is_cer))
            || (STOP_INSTR_I && is_xtal)) begin
            // RL16 held set while reset high
            r_next.halt_ff = 1'b1;
        end else if (is_xtal) begin
            // RL14 release or end of internal reset
            if (RELEASE_I || (r_reg.int_reset && !r_next.int_reset)) begin
                r_next.halt_ff = 1'b0;
            end else if (HALT_INSTR_I) begin
                r_next.halt_ff = 1'b1;
            end
        end else if (RELEASE_I || rst_fall) begin
            r_next.halt_ff = 1'b0;
        end else if (HALT_INSTR_I) begin
            r_next.halt_ff = 1'b1;
        end

        // RL7 cpu enable masked while reset pin is high and stop ff still set; not crystal or ceramic
        if (rst_hi && !is_cer && !is_xtal) begin
            r_next.en.cpu     = r_next.en.cpu & ~r_reg.stop_ff;
        end

        unique case ({r_next.stop_ff, r_next.halt_ff})
            2'b00:   r_next.st = scd_pkg::SCD_ST_RUN;
            2'b01:   r_next.st = scd_pkg::SCD_ST_HALT;
            2'b10,
            2'b11:   r_next.st = scd_pkg::SCD_ST_STOP;
        endcase
        if (r_next.int_reset && !rst_hi) begin
            r_next.st = scd_pkg::SCD_ST_WAIT;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // RL6 base clock drives timer and interrupt sync
    assign CLK_EN_O                 = r_reg.en;
    assign INT_SYNC_EN_O            = r_reg.en.base;
    // RL12 timer control input from system clock in crystal variant
    assign TIMER_COUNT_PULSE_EN_O   = (VARIANT_I == scd_pkg::SCD_VAR_XTAL)
                                    ? r_reg.en.base : r_reg.en.timer
                                      | r_reg.en.base;
    assign DELAYED_INTERNAL_RESET_O = r_reg.int_reset;
    assign HALT_O                   = r_reg.halt_ff;
    assign STOP_O                   = r_reg.stop_ff;

    property p_halt_blocks_cpu;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.halt_ff |=> !r_reg.en.cpu;
    endproperty
    a_halt_blocks_cpu: assert property (p_halt_blocks_cpu) // RL3
        else $error("cpu enable while halted");

    property p_stop_blocks_cpu;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.stop_ff |=> !r_reg.en.cpu;
    endproperty
    a_stop_blocks_cpu: assert property (p_stop_blocks_cpu) // RL2
        else $error("cpu enable while stopped");

    property p_reset_clears_stop;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.rst_sync[1] |=> !r_reg.stop_ff;
    endproperty
    a_reset_clears_stop: assert property (p_reset_clears_stop) // RL7
        else $error("stop ff not cleared by reset");

    property p_cer_reset_halts;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (VARIANT_I == scd_pkg::SCD_VAR_CERAMIC) && r_reg.rst_sync[1]
        |=> r_reg.halt_ff;
    endproperty
    a_cer_reset_halts: assert property (p_cer_reset_halts) // RL16
        else $error("halt ff not held during reset");

    property p_halt_release;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        RELEASE_I && !r_reg.rst_sync[1] && !STOP_INSTR_I |=> !r_reg.halt_ff;
    endproperty
    a_halt_release: assert property (p_halt_release) // RL8
        else $error("release did not clear halt");

    property p_stop_instr;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        STOP_INSTR_I && !r_reg.rst_sync[1] && !RELEASE_I
        && (VARIANT_I != scd_pkg::SCD_VAR_CERAMIC) |=> r_reg.stop_ff;
    endproperty
    a_stop_instr: assert property (p_stop_instr) // RL7
        else $error("stop instruction did not set stop ff");

    property p_xtal_stop_clears_div;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.stop_ff && !r_reg.ext_sync[1] |=> r_reg.osc_cnt == 8'h00;
    endproperty
    a_xtal_stop_clears_div: assert property (p_xtal_stop_clears_div) // RL13
        else $error("divider not cleared in stop");

    property p_int_reset_wait;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        $fell(r_reg.rst_sync[1]) |-> r_reg.int_reset;
    endproperty
    a_int_reset_wait: assert property (p_int_reset_wait) // RL14
        else $error("internal reset dropped with pin");

    property p_cpu_on_base;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.en.cpu |-> r_reg.en.base;
    endproperty
    a_cpu_on_base: assert property (p_cpu_on_base) // RL18
        else $error("cpu enable without base enable");

    property p_cpu_no_repeat;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.en.cpu |=> !r_reg.en.cpu;
    endproperty
    a_cpu_no_repeat: assert property (p_cpu_no_repeat) // RL1
        else $error("cpu enable on two cycles in a row");

    property p_ext_base_runs;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.ext_sync[1] && OSC_TICK_I && !is_xc && !is_xtal
        |=> r_reg.en.base;
    endproperty
    a_ext_base_runs: assert property (p_ext_base_runs) // RL4
        else $error("base clock lost with external clock");

    property p_pg_with_display;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.en.display |-> r_reg.en.pulse_gen;
    endproperty
    a_pg_with_display: assert property (p_pg_with_display) // RL11
        else $error("display phase without pulse generator phase");

    property p_timer_with_display;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        is_xtal && r_reg.en.timer |-> r_reg.en.display;
    endproperty
    a_timer_with_display: assert property (p_timer_with_display) // RL9
        else $error("timer phase off the slow chain");

    property p_slow_select;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        is_xtal && !$past(CLOCK_SPEED_SELECT_BIT_I) && r_reg.en.base
        |-> r_reg.en.display;
    endproperty
    a_slow_select: assert property (p_slow_select) // RL10
        else $error("slow system clock off the slow chain");

    property p_res_release_stop;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.stop_ff && RELEASE_I && is_resistor |=> !r_reg.stop_ff;
    endproperty
    a_res_release_stop: assert property (p_res_release_stop) // RL17
        else $error("interrupt did not leave stop");

    property p_stop_only_reset;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        r_reg.stop_ff && !r_reg.rst_sync[1] && !is_resistor
        |=> r_reg.stop_ff;
    endproperty
    a_stop_only_reset: assert property (p_stop_only_reset) // RL17
        else $error("stop left without reset");

    property p_xtal_stop_halts;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        STOP_INSTR_I && is_xtal |=> r_reg.halt_ff;
    endproperty
    a_xtal_stop_halts: assert property (p_xtal_stop_halts) // RL14
        else $error("stop instruction did not set halt ff");

    sequence s_halt_request;
        HALT_INSTR_I && !RELEASE_I && !rst_fall && !r_reg.int_reset;
    endsequence

    sequence s_cpu_blocked;
        r_reg.halt_ff ##1 !r_reg.en.cpu;
    endsequence

    property p_halt_then_block;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        s_halt_request |=> s_cpu_blocked;
    endproperty
    a_halt_then_block: assert property (p_halt_then_block) // RL8
        else $error("halt instruction did not block cpu");
endmodule // scd_standby_clock
`default_nettype wire

// file: verif/scd_cpu_model.sv
`default_nettype none
module scd_cpu_model (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // enables seen downstream, count window clear
    input  wire scd_pkg::scd_clk_en_t en_i,
    input  wire logic                 clr_i,
    // pulse counts: base, cpu, copy, timer, pulse gen, display
    output logic [5:0][15:0]          cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] en_v;
    assign en_v = {en_i.display, en_i.pulse_gen, en_i.timer,
                   en_i.cpu_out, en_i.cpu, en_i.base};
    // counts stay x from an x enable until clr_i clears them, so bad levels never pass
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_o <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                cnt_o[i] <= clr_i ? 16'h0000 : cnt_o[i] + 16'(en_v[i]);
            end
        end
    end
endmodule // scd_cpu_model
`default_nettype wire

// file: verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAIT = 4;
    localparam int N    = 512;
    logic                  clk_sys = 1'b0;
    logic                  arst_n  = 1'b0;
    scd_pkg::scd_variant_t variant = scd_pkg::SCD_VAR_RC;
    logic                  ext_clk = 1'b0;
    logic                  fast16  = 1'b0;
    logic                  sel     = 1'b0;
    logic                  stop_in = 1'b0;
    logic                  halt_in = 1'b0;
    logic                  rel     = 1'b0;
    logic                  pin     = 1'b0;
    logic                  clr     = 1'b0;
    scd_pkg::scd_clk_en_t  en;
    logic                  tcp;
    logic                  isync;
    logic                  dly_rst;
    logic                  halt;
    logic                  stop;
    logic [5:0][15:0]      cnt;
    logic [15:0]           cnt_isync;
    logic [15:0]           cnt_tcp;
    int                    miscompares = 0;
    int                    check_count = 0;
    always #10 clk_sys = ~clk_sys;
    scd_standby_clock #(.WAIT_CYC(WAIT)) dut_u (
        .CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .VARIANT_I(variant),
        .EXT_CLOCK_I(ext_clk), .FAST16_PART_I(fast16),
        .CLOCK_SPEED_SELECT_BIT_I(sel), .OSC_TICK_I(1'b1),
        .STOP_INSTR_I(stop_in), .HALT_INSTR_I(halt_in),
        .RELEASE_I(rel), .RESET_PIN_I(pin), .CLK_EN_O(en),
        .TIMER_COUNT_PULSE_EN_O(tcp), .INT_SYNC_EN_O(isync),
        .DELAYED_INTERNAL_RESET_O(dly_rst), .HALT_O(halt), .STOP_O(stop));
    scd_cpu_model cpu_u (.clk_i(clk_sys), .arst_n_i(arst_n), .en_i(en),
                         .clr_i(clr), .cnt_o(cnt));
    always @(posedge clk_sys) begin
        cnt_isync <= clr ? 16'h0000 : cnt_isync + 16'(isync);
        cnt_tcp   <= clr ? 16'h0000 : cnt_tcp + 16'(tcp);
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, lo);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_rng({15'h0000, got}, int'(exp), int'(exp));
    endtask
    // one pulse of slack for the phase of the window
    task automatic chk_cnt(input int i, input int exp);
        chk_rng(cnt[i], (exp > 0) ? exp - 1 : 0, (exp > 0) ? exp + 1 : 0);
    endtask
    task automatic meas();
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(N);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(2);
    endtask
    task automatic setup(input scd_pkg::scd_variant_t v);
        arst_n = 1'b0;
        variant = v;
        step(2);
        arst_n = 1'b1;
        step(WAIT + 6);
    endtask
    task automatic t_rc_halt();
        setup(scd_pkg::SCD_VAR_RC);
        meas();
        chk_cnt(0, N);
        chk_cnt(1, N / 2);
        pulse(halt_in);
        chk_bit(halt, 1'b1);
        meas();
        chk_cnt(0, N);
        chk_cnt(1, 0);
        pulse(rel);
        chk_bit(halt, 1'b0);
        pulse(halt_in);
        pulse(pin);
        step(3);
        chk_bit(halt, 1'b0);
        $display("test rc halt done");
    endtask
    task automatic t_rc_stop();
        setup(scd_pkg::SCD_VAR_RC);
        pulse(stop_in);
        chk_bit(stop, 1'b1);
        meas();
        chk_cnt(0, 0);
        chk_cnt(1, 0);
        pulse(rel);
        chk_bit(stop, 1'b0);
        ext_clk = 1'b1;
        step(3);
        pulse(stop_in);
        meas();
        chk_cnt(0, N);
        chk_cnt(1, 0);
        pulse(rel);
        ext_clk = 1'b0;
        $display("test rc stop done");
    endtask
    task automatic t_r_stop();
        setup(scd_pkg::SCD_VAR_R);
        pulse(stop_in);
        chk_bit(stop, 1'b1);
        meas();
        chk_cnt(0, 0);
        pulse(rel);
        chk_bit(stop, 1'b0);
        $display("test r stop done");
    endtask
    task automatic t_xc_div();
        setup(scd_pkg::SCD_VAR_XTALCER);
        meas();
        chk_cnt(0, N / 6);
        chk_cnt(1, N / 12);
        chk_cnt(2, N / 12);
        chk_cnt(3, N / 8);
        chk_rng(cnt_isync, N / 6 - 1, N / 6 + 1);
        $display("test xc div done");
    endtask
    task automatic t_xt_div();
        setup(scd_pkg::SCD_VAR_XTAL);
        sel = 1'b1;
        meas();
        chk_cnt(0, N / 8);
        chk_cnt(1, N / 16);
        chk_cnt(3, N / 128);
        chk_cnt(4, N / 2);
        chk_cnt(5, N / 32);
        chk_rng(cnt_tcp, N / 8 - 1, N / 8 + 1);
        sel = 1'b0;
        meas();
        chk_cnt(0, N / 32);
        chk_cnt(1, N / 64);
        chk_cnt(4, N / 2);
        chk_cnt(5, N / 32);
        fast16 = 1'b1;
        sel = 1'b1;
        meas();
        chk_cnt(0, N / 16);
        fast16 = 1'b0;
        $display("test xt div done");
    endtask
    task automatic t_xt_stop();
        int k;
        setup(scd_pkg::SCD_VAR_XTAL);
        pulse(stop_in);
        chk_bit(stop, 1'b1);
        chk_bit(halt, 1'b1);
        meas();
        chk_cnt(0, 0);
        chk_cnt(4, 0);
        chk_cnt(5, 0);
        pulse(rel);
        chk_bit(stop, 1'b1);
        pin = 1'b1;
        step(4);
        chk_bit(stop, 1'b0);
        chk_bit(dly_rst, 1'b1);
        chk_bit(halt, 1'b1);
        pin = 1'b0;
        k = 0;
        while (dly_rst === 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        chk_rng(16'(k), WAIT, WAIT + 6);
        step(2);
        chk_bit(halt, 1'b0);
        $display("test xt stop done");
    endtask
    task automatic t_cer();
        setup(scd_pkg::SCD_VAR_CERAMIC);
        pin = 1'b1;
        step(4);
        chk_bit(halt, 1'b1);
        meas();
        chk_cnt(0, N);
        chk_cnt(1, 0);
        pin = 1'b0;
        step(6);
        meas();
        chk_cnt(1, N / 2);
        pulse(stop_in);
        chk_bit(stop, 1'b0);
        $display("test ceramic done");
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        step(2);
        t_rc_halt();
        t_rc_stop();
        t_r_stop();
        t_xc_div();
        t_xt_div();
        t_xt_stop();
        t_cer();
        end_sim();
    end
    // about 6300 cycles expected; a hang is cut well beyond that
    initial begin
        #500000;
        miscompares++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
